// ===== dv/pm_cap_checker.sv
// port assertions for the power management words
`timescale 1ns/1ps
module pm_cap_checker
   import pm_cap_pkg::*;
(
   // watched ports
   input wire logic clk,
   input wire logic arst_n,
   input wire cfg_req_t cfg_req,
   input wire logic [15:0] cfg_rdata,
   input wire logic [2:0] local_flags,
   input wire logic [1:0] mirrored_power_state,
   input wire logic local_event_request_bit,
   input wire logic event_assert_enable_o,
   input wire logic event_out_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // control word access decode
   wire logic wr_csr = cfg_req.wr && cfg_req.addr == 8'hE0;
   wire logic rd_csr = cfg_req.rd && cfg_req.addr == 8'hE0;
   property p_cap; cfg_req.rd && cfg_req.addr == 8'hDE |=> cfg_rdata == 16'h4802; endproperty
   a_cap: assert property (p_cap) else $error("cap word");
   property p_rsv; rd_csr |=> (cfg_rdata & 16'h7EFC) == 16'h0000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_en; wr_csr && cfg_req.be[1] && cfg_req.wdata[8] |-> ##[1:2] event_assert_enable_o; endproperty
   a_en: assert property (p_en) else $error("enable");
   property p_blk; !event_out_n |-> event_assert_enable_o || $past(event_assert_enable_o); endproperty
   a_blk: assert property (p_blk) else $error("event blocked");
   property p_evt; local_event_request_bit && event_assert_enable_o |-> ##[1:3] !event_out_n; endproperty
   a_evt: assert property (p_evt) else $error("event");
   property p_esf; $rose(event_assert_enable_o) |-> ##[0:1] local_flags[2]; endproperty
   a_esf: assert property (p_esf) else $error("enable flag");
   property p_psc; $changed(mirrored_power_state) |-> local_flags[1]; endproperty
   a_psc: assert property (p_psc) else $error("state flag");
   property p_mir; wr_csr && cfg_req.be[0] |-> ##2 mirrored_power_state == $past(cfg_req.wdata[1:0], 2); endproperty
   a_mir: assert property (p_mir) else $error("mirror");
   c_evt: cover property (!event_out_n);
   c_psc: cover property ($changed(mirrored_power_state));
   c_rd: cover property (rd_csr);
endmodule : pm_cap_checker
bind pci_power_mgmt_capability pm_cap_checker chk (.*);

// ===== dv/pm_host_model.sv
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
module pm_host_model
   import pm_cap_pkg::*;
(
   // bus side
   input wire logic clk,
   input wire logic [15:0] cfg_rdata,
   input wire logic cfg_rvalid,
   output cfg_req_t cfg_req
);
   initial cfg_req = '0;
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] w);
      @(posedge clk) cfg_req <= '{a, b, 1'b1, 1'b0, w};
      @(posedge clk) cfg_req.wr <= 1'b0;
   endtask : wr
   // read strobe, answer taken one cycle on
   task automatic rd(input logic [7:0] a, output logic [15:0] r, output logic v);
      @(posedge clk) cfg_req <= '{a, 2'b11, 1'b0, 1'b1, 16'h0000};
      @(posedge clk) cfg_req.rd <= 1'b0;
      @(posedge clk) v = cfg_rvalid;
      r = cfg_rdata;
   endtask : rd
endmodule : pm_host_model

// ===== dv/testbench.sv
// bench for the power management capability words
`timescale 1ns/1ps
module testbench;
   import pm_cap_pkg::*;
   logic clk, arst_n, local_event_request_bit, cfg_rvalid, event_assert_enable_o, event_out_n, v;
   logic [2:0] local_flag_clear, local_flags;
   logic [1:0] mirrored_power_state;
   logic [15:0] cfg_rdata, d;
   cfg_req_t cfg_req;
   int n_fail = 0;
   int cmp_count = 0;
   pci_power_mgmt_capability dut (.*);
   pm_host_model host (.*);
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask : check
   // read with answer flag and value
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      host.rd(a, d, v);
      check({15'h0, v}, 16'h0001);
      check(d, e);
   endtask : rdc
   task automatic pulse;
      @(posedge clk) local_event_request_bit <= 1'b1;
      @(posedge clk) local_event_request_bit <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : pulse
   // fixed words, refused write, unmapped place
   task automatic t_ids;
      host.wr(8'hDE, 2'b11, 16'hFFFF);
      rdc(8'hDC, 16'h0001);
      rdc(8'hDE, 16'h4802);
      rdc(8'hE0, 16'h0000);
      rdc(8'hF0, 16'h0000);
   endtask : t_ids
   // every state code, mirror, change flag
   task automatic t_ps;
      for (int s = 3; s >= 0; s--) begin
         host.wr(8'hE0, 2'b01, {14'h3FFF, s[1:0]});
         rdc(8'hE0, {14'h0, s[1:0]});
         check({14'h0, mirrored_power_state}, {14'h0, s[1:0]});
         check({13'h0, local_flags}, 16'h0002);
         @(posedge clk) local_flag_clear <= 3'h2;
         @(posedge clk) local_flag_clear <= 3'h0;
      end
   endtask : t_ps
   // enable, event, zero write, clear, blocked event
   task automatic t_evt;
      host.wr(8'hE0, 2'b10, 16'h0100);
      @(negedge clk) check({13'h0, local_flags}, 16'h0004);
      pulse();
      check({15'h0, event_out_n}, 16'h0000);
      host.wr(8'hE0, 2'b10, 16'h0100);
      rdc(8'hE0, 16'h8100);
      host.wr(8'hE0, 2'b10, 16'h8100);
      rdc(8'hE0, 16'h0100);
      check({12'h0, local_flags, event_out_n}, 16'h000B);
      host.wr(8'hE0, 2'b10, 16'h0000);
      pulse();
      check({15'h0, event_out_n}, 16'h0001);
   endtask : t_evt
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // reset, then the scenarios
   initial begin
      arst_n = 1'b0;
      local_event_request_bit = 1'b0;
      local_flag_clear = 3'h0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_ids();
      t_ps();
      t_evt();
      finish_test();
   end
   // watchdog at 1000 cycles, well past the roughly 90 cycles of the run
   initial begin
      #40000;
      n_fail++;
      finish_test();
   end
endmodule : testbench

// ===== logic/pci_power_mgmt_capability.sv
// power management capability and control/status words in config space
`timescale 1ns/1ps
`include "pm_cap_cfg.svh"
module pci_power_mgmt_capability
   import pm_cap_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // configuration access from the bus target
   input wire cfg_req_t cfg_req,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   // local side
   input wire logic local_event_request_bit,
   input wire logic [2:0] local_flag_clear,
   output logic [2:0] local_flags,
   output logic [1:0] mirrored_power_state,
   output logic event_assert_enable_o,
   output logic event_out_n
);
   // register map, byte addresses on the configuration side:
   //   0xDC capability id, next pointer in the upper byte
   //   0xDD next pointer alone, upper byte zero
   //   0xDE capability word, a constant image
   //   0xE0 control/status word
   // any other address reads zero and drops writes
   //
   // bus timing:
   //   a request counts on the edge where rd or wr is high
   //   read data and rvalid follow one edge later, from flops
   //   write effects land in the state flops one edge later
   //   local copies (mirror, event pin) trail the state by one edge
   //
   // state flops of the control/status word
   logic event_status_flag_q;
   logic event_assert_enable_q;
   power_state_t power_state_field_q;
   logic [15:0] cfg_rdata_q;
   logic cfg_rvalid_q;
   logic [1:0] mirror_q;
   logic event_out_n_q;
   logic [2:0] flag_set;
   logic [2:0] flags_w;

   // byte lanes matter: the host may write only the state byte,
   // so a status clear or enable change needs be[1] and a state
   // change needs be[0]; a lane left off keeps its bits untouched
   // decode of a write to the control/status word low or high byte
   function automatic logic csr_byte_wr(input cfg_req_t r, input int lane);
      csr_byte_wr = r.wr && (r.addr == `PM_OFF_CSR_WORD) && r.be[lane];
   endfunction : csr_byte_wr

   // capability word image
   function automatic logic [15:0] cap_word();
      logic [15:0] w;
      w = 16'h0000;
      w[15:11] = `PM_EVT_STATES_VAL;
      w[10] = 1'b0;
      w[9] = 1'b0;
      w[5] = 1'b0;
      w[3] = 1'b0;
      w[2:0] = `PM_VERSION_VAL;
      cap_word = w;
   endfunction : cap_word

   logic wr_lo;
   logic wr_hi;
   logic status_clr;
   logic [1:0] ps_new;
   assign wr_lo = csr_byte_wr(cfg_req, 0);
   assign wr_hi = csr_byte_wr(cfg_req, 1);
   assign status_clr = wr_hi && cfg_req.wdata[`PM_CSR_STATUS_BIT];
   assign ps_new = cfg_req.wdata[1:0];

   // a local request and a host clear can land on the same edge;
   // the request wins so that an event is never lost, and the host
   // sees the flag again on its next read and clears it once more
   // event status, local request wins over host clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         event_status_flag_q <= 1'b0;
      end else if (local_event_request_bit) begin
         event_status_flag_q <= 1'b1;
      end else if (status_clr) begin
         event_status_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         event_assert_enable_q <= 1'b0;
      end else if (wr_hi) begin
         event_assert_enable_q <= cfg_req.wdata[`PM_CSR_ENABLE_BIT];
      end
   end

   // reserved codes are kept as written rather than refused, so a
   // read back shows the host exactly what it wrote; local software
   // sees the same code through the mirror and decides what to do
   // power state field, all codes stored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_state_field_q <= power_state_t'(`PM_STATE_RST);
      end else if (wr_lo) begin
         power_state_field_q <= power_state_t'(ps_new);
      end
   end

   // the event sources below compare against the flop value before
   // the write lands, so a rewrite of the same enable or state value raises nothing
   // local event sources: enable set, state change, event cleared
   always_comb begin
      flag_set[2] = wr_hi && cfg_req.wdata[`PM_CSR_ENABLE_BIT] && !event_assert_enable_q;
      flag_set[1] = wr_lo && (ps_new != power_state_field_q);
      flag_set[0] = status_clr && event_status_flag_q;
   end

   // sticky local flags, cleared by local software through a per-bit mask;
   // a set in the same cycle as its clear keeps the flag up
   pm_event_flags #(
      .N(3)
   ) u_flags (
      .clk(clk),
      .arst_n(arst_n),
      .set_pulse(flag_set),
      .clr_pulse(local_flag_clear),
      .flags(flags_w)
   );

   // the read image is taken from the state flops on the request edge,
   // so a write and a read on the same edge return the old value;
   // the data then stand until the next read, rvalid for one cycle
   // read path, registered; reserved bits zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_rdata_q <= 16'h0000;
         cfg_rvalid_q <= 1'b0;
      end else begin
         cfg_rvalid_q <= cfg_req.rd;
         if (cfg_req.rd) begin
            case (cfg_req.addr)
               `PM_OFF_CAP_ID: cfg_rdata_q <= {`PM_NEXT_PTR_VAL, `PM_CAP_ID_VAL};
               `PM_OFF_NEXT_PTR: cfg_rdata_q <= {8'h00, `PM_NEXT_PTR_VAL};
               `PM_OFF_CAP_WORD: cfg_rdata_q <= cap_word();
               `PM_OFF_CSR_WORD: cfg_rdata_q <= {event_status_flag_q, 6'h00, event_assert_enable_q,
                                                 6'h00, power_state_field_q};
               default: cfg_rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   // both copies trail the state by one edge so that every output
   // comes straight from a flop; the event pin idles high (inactive)
   // and falls only while status and enable are both set
   // mirror and event pin, both registered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mirror_q <= 2'b00;
         event_out_n_q <= 1'b1;
      end else begin
         mirror_q <= power_state_field_q;
         event_out_n_q <= !(event_status_flag_q && event_assert_enable_q);
      end
   end

   // outputs, each a plain copy of its flop
   assign cfg_rdata = cfg_rdata_q;
   assign cfg_rvalid = cfg_rvalid_q;
   assign local_flags = flags_w;
   assign mirrored_power_state = mirror_q;
   assign event_assert_enable_o = event_assert_enable_q;
   assign event_out_n = event_out_n_q;
endmodule : pci_power_mgmt_capability

// ===== logic/pm_cap_cfg.svh
// constants for the power management capability block
`ifndef PM_CAP_CFG_SVH
`define PM_CAP_CFG_SVH
`define PM_OFF_CAP_ID 8'hDC
`define PM_OFF_NEXT_PTR 8'hDD
`define PM_OFF_CAP_WORD 8'hDE
`define PM_OFF_CSR_WORD 8'hE0
`define PM_CAP_ID_VAL 8'h01
`define PM_NEXT_PTR_VAL 8'h00
`define PM_EVT_STATES_VAL 5'h09
`define PM_VERSION_VAL 3'h2
`define PM_STATE_RST 2'h0
`define PM_CSR_STATUS_BIT 15
`define PM_CSR_ENABLE_BIT 8
`endif

// ===== logic/pm_cap_pkg.sv
// types for the power management capability block
package pm_cap_pkg;
   typedef enum logic [1:0] {
      PS_D0 = 2'b00,
      PS_D1_RSVD = 2'b01,
      PS_D2_RSVD = 2'b10,
      PS_D3HOT = 2'b11
   } power_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [1:0] be;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic enable_set_flag;
      logic state_change_flag;
      logic event_clear_flag;
   } local_flags_t;
endpackage : pm_cap_pkg

// ===== logic/pm_event_flags.sv
// sticky local status flags with set-over-clear
`timescale 1ns/1ps
module pm_event_flags
   import pm_cap_pkg::*;
#(
   parameter int N = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // events and clears
   input wire logic [N-1:0] set_pulse,
   input wire logic [N-1:0] clr_pulse,
   // flags
   output logic [N-1:0] flags
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_flag
         // set wins over clear
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               flags[i] <= 1'b0;
            end else if (set_pulse[i]) begin
               flags[i] <= 1'b1;
            end else if (clr_pulse[i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule : pm_event_flags
